// >>> src/multiframe_stretch.sv
`timescale 1ns/1ps
`default_nettype none

`include "rx_ais_defines.svh"

// Holds an alarm for one multiframe after each trigger pulse.
module multiframe_stretch
    import rx_ais_pkg::*;
#(
    parameter int MF_CYCLES = `MF_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic trigger,
    output logic hold
);

    stretch_regs_t st_reg; // Registered state.
    stretch_regs_t st_next; // Next state.

    // Counts down the multiframe; a new trigger restarts it.
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            ST_IDLE: begin
                if (trigger) begin
                    st_next.state = ST_HOLD;
                    st_next.cnt = `MF_CNT_WIDTH'(MF_CYCLES - 1);
                end
            end
            ST_HOLD: begin
                if (trigger) begin
                    st_next.cnt = `MF_CNT_WIDTH'(MF_CYCLES - 1);
                end else if (st_reg.cnt == '0) begin
                    st_next.state = ST_IDLE;
                end else begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    // Registers the state.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // The hold flag is the state bit itself.
    assign hold = (st_reg.state == ST_HOLD);

    // A trigger arms the full multiframe count.
    sequence s_armed;
        hold && st_reg.cnt == `MF_CNT_WIDTH'(MF_CYCLES - 1);
    endsequence

    // Hold stays up while counting down.
    sequence s_counting;
        hold [*2];
    endsequence

    property p_hold_start;
        @(posedge sys_clk) disable iff (sys_rst)
        trigger |=> s_armed;
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("Stretch did not arm on trigger.");

    property p_hold_count;
        @(posedge sys_clk) disable iff (sys_rst)
        (hold && !trigger && st_reg.cnt > `MF_CNT_WIDTH'(1)) |=>
        (st_reg.cnt == $past(st_reg.cnt) - 1'b1) ##0 s_counting;
    endproperty
    a_hold_count: assert property (p_hold_count)
        else $error("Stretch count did not step down.");

    property p_hold_end;
        @(posedge sys_clk) disable iff (sys_rst)
        (hold && !trigger && st_reg.cnt == '0) |=> !hold;
    endproperty
    a_hold_end: assert property (p_hold_end)
        else $error("Stretch did not end after one multiframe.");

endmodule : multiframe_stretch

`default_nettype wire

// >>> src/rx_ais_defines.svh
`ifndef RX_AIS_DEFINES_SVH
`define RX_AIS_DEFINES_SVH

// Number of E1 ports served by this block.
`define NUM_PORTS 4

// Register indices on the plain register port.
`define RA_CTRL 4'h0
`define RA_PORT 4'h1
`define RA_TRIB0 4'h4
`define RA_TRIB1 4'h5
`define RA_TRIB2 4'h6
`define RA_TRIB3 4'h7
`define RA_ALARM_STATE 4'h8
`define RA_IRQ_STATUS 4'h9
`define RA_IRQ_CLEAR 4'hA
`define RA_IRQ_ENABLE 4'hB

// Control register layout, bit 8 down to bit 0.
`define CTRL_WIDTH 9
`define CTRL_LINE_ALARM_EN_BIT 8
`define CTRL_UPSTREAM_EN_BIT 7
`define CTRL_V1_SOURCE_BIT 6
`define CTRL_UNEQ_EN_BIT 5
`define CTRL_TRACE_CMP_BIT 4
`define CTRL_TRACE_ALARM_BIT 3
`define CTRL_TRACE_SIZE_BIT 2
`define CTRL_TANDEM_EN_BIT 1
`define CTRL_TANDEM_ALARM_BIT 0

// Port control layout: side selects low, force bits above.
`define PORT_SIDE_LSB 0
`define PORT_FORCE_LSB 4

// Tributary number layout: segment in bits 6:5, index in bits 4:0.
`define TRIB_WIDTH 7
`define TRIB_SEG_MSB 6
`define TRIB_SEG_LSB 5
`define TRIB_IDX_MSB 4
`define TRIB_IDX_MAX 5'h15

// Reset values.
`define CTRL_RESET 9'h000
`define PORT_RESET 8'h00
`define TRIB_RESET 7'h00
`define IRQ_ENABLE_RESET 4'h0

// Multiframe length in time and in core clock cycles.
`define MF_TIME_NS 500000
`define CLK_PERIOD_NS 8
`define MF_CYCLES ((`MF_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MF_CNT_WIDTH 16

`endif

// >>> src/rx_ais_pkg.sv
`include "rx_ais_defines.svh"

package rx_ais_pkg;

    // Alarms of one port on one drop side, from the detectors.
    typedef struct packed {
        logic loss_of_pointer;
        logic trib_alarm_ind;
        logic drop_clock_loss;
        logic label_unequipped;
        logic label_mismatch;
        logic trace_lock_loss;
        logic trace_mismatch;
        logic tandem_unequipped;
        logic tandem_lock_loss;
        logic tandem_trace_mismatch;
        logic tandem_multiframe_loss;
        logic tandem_alarm_ind;
    } side_alarm_t;

    // Shared qualifier bits, in the order of the control register.
    typedef struct packed {
        logic rx_line_alarm_enable;
        logic upstream_alarm_enable;
        logic v1_source_select;
        logic unequipped_alarm_enable;
        logic trace_compare_enable;
        logic trace_alarm_enable;
        logic trace_size_select;
        logic tandem_enable;
        logic tandem_alarm_enable;
    } qual_cfg_t;

    // One request on the register port.
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Whole state of the top module.
    typedef struct packed {
        qual_cfg_t cfg;
        logic [3:0] side_sel;
        logic [3:0] force_alarm;
        logic [3:0][`TRIB_WIDTH-1:0] trib;
        logic [3:0] ais;
        logic [3:0] data_out;
        logic [3:0] irq_status;
        logic [3:0] irq_enable;
        logic irq;
        logic [15:0] rd_data;
    } ctrl_state_t;

    // States of the FIFO error stretcher.
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_HOLD = 1'b1
    } stretch_state_t;

    // Whole state of the stretcher.
    typedef struct packed {
        stretch_state_t state;
        logic [`MF_CNT_WIDTH-1:0] cnt;
    } stretch_regs_t;

    // Picks the bit of the bus segment that carries the tributary.
    function automatic logic seg_pick(input logic [2:0] bits,
                                      input logic [1:0] seg);
        logic r;
        r = 1'b0;
        case (seg)
            2'h1: r = bits[0];
            2'h2: r = bits[1];
            2'h3: r = bits[2];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : seg_pick

    // A tributary number is valid with a segment 1-3 and index 1-21.
    function automatic logic trib_valid(
        input logic [`TRIB_WIDTH-1:0] tun);
        logic [1:0] seg;
        logic [4:0] idx;
        seg = tun[`TRIB_SEG_MSB:`TRIB_SEG_LSB];
        idx = tun[`TRIB_IDX_MSB:0];
        return (seg != 2'h0) && (idx != 5'h00) && (idx <= `TRIB_IDX_MAX);
    endfunction : trib_valid

endpackage : rx_ais_pkg

// >>> src/rx_e1_ais_insert_ctrl.sv
// Functional notes
// - Shared enable lets internal alarms send AIS.
// - AIS output is unframed all ones.
// - A side: pointer, tributary, clock loss alarm.
// - A side upstream alarm under its enable.
// - A side H4 error when V1 source 0.
// - Label mismatch; unequipped under its enable.
// - Trace alarms with compare, enable, size 0.
// - Tandem alarms with tandem and alarm enable.
// - B side: pointer, tributary, clock loss alarm.
// - B side upstream alarm under its enable.
// - B side gets the same qualified triggers.
// - FIFO error sends AIS one multiframe.
// - Software force bit sends AIS always.
// - Invalid tributary number sends AIS.
// - Segment inputs follow the selected tributary.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "rx_ais_defines.svh"

module rx_e1_ais_insert_ctrl
    import rx_ais_pkg::*;
#(
    parameter int MF_CYCLES = `MF_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire reg_req_t reg_req,
    output logic [15:0] reg_rd_data,
    input wire side_alarm_t [3:0] a_side,
    input wire side_alarm_t [3:0] b_side,
    input wire logic [2:0] a_upstream_alarm,
    input wire logic [2:0] b_upstream_alarm,
    input wire logic [2:0] a_multiframe_byte_error,
    input wire logic [2:0] b_multiframe_byte_error,
    input wire logic [3:0] rx_fifo_error,
    input wire logic [3:0] rx_e1_data_in,
    output logic [3:0] rx_e1_data_out,
    output logic [3:0] rx_alarm_active,
    output logic irq
);

    ctrl_state_t st_reg; // Registered state of the block.
    ctrl_state_t st_next; // Next value of the state.

    logic [3:0] qual_a; // Qualified A side alarm per port.
    logic [3:0] qual_b; // Qualified B side alarm per port.
    logic [3:0] fifo_hold; // One multiframe hold after FIFO error.
    logic [3:0] fifo_trig; // FIFO error accepted by the enable.
    logic [3:0] cause; // Combined alarm request per port.
    logic [3:0] irq_clear; // Status bits cleared by this write.
    logic [3:0] rise; // Ports whose alarm starts now.

    // Each port has its own qualifiers and its own FIFO hold timer.
    genvar p;
    generate
        for (p = 0; p < `NUM_PORTS; p++) begin : g_port
            logic [1:0] seg; // Bus segment of the tributary.

            // Segment inputs come from the tributary's own segment.
            assign seg = st_reg.trib[p][`TRIB_SEG_MSB:`TRIB_SEG_LSB];

            // Qualification of the A side.
            side_alarm_qual u_qual_a (
                .side(a_side[p]),
                .seg_upstream(seg_pick(a_upstream_alarm, seg)),
                .seg_h4_error(seg_pick(a_multiframe_byte_error, seg)),
                .cfg(st_reg.cfg),
                .alarm(qual_a[p])
            );

            // Qualification of the B side.
            side_alarm_qual u_qual_b (
                .side(b_side[p]),
                .seg_upstream(seg_pick(b_upstream_alarm, seg)),
                .seg_h4_error(seg_pick(b_multiframe_byte_error, seg)),
                .cfg(st_reg.cfg),
                .alarm(qual_b[p])
            );

            // A FIFO error counts only while line alarms are enabled.
            assign fifo_trig[p] = rx_fifo_error[p] &
                                  st_reg.cfg.rx_line_alarm_enable;

            // Stretches the FIFO error to one multiframe.
            multiframe_stretch #(
                .MF_CYCLES(MF_CYCLES)
            ) u_stretch (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .trigger(fifo_trig[p]),
                .hold(fifo_hold[p])
            );
        end
    endgenerate

    // Decodes the clear register, which holds no state of its own.
    always_comb begin
        irq_clear = 4'h0;
        if (reg_req.wr && reg_req.addr == `RA_IRQ_CLEAR) begin
            irq_clear = reg_req.wdata[3:0];
        end
    end

    // Computes the alarm request of every port.
    always_comb begin
        for (int i = 0; i < `NUM_PORTS; i++) begin
            // The selected side decides which qualified alarm counts.
            cause[i] = (st_reg.side_sel[i] ? qual_b[i] : qual_a[i]) |
                       (fifo_hold[i] &
                        st_reg.cfg.rx_line_alarm_enable) |
                       st_reg.force_alarm[i] |
                       ~trib_valid(st_reg.trib[i]);
        end
        rise = cause & ~st_reg.ais;
    end

    // Builds the next state: register writes, alarms, data and reads.
    always_comb begin
        st_next = st_reg;
        st_next.rd_data = 16'h0000;

        // Register writes; the clear register is decoded above.
        if (reg_req.wr) begin
            if (reg_req.addr == `RA_CTRL) begin
                st_next.cfg = qual_cfg_t'(reg_req.wdata[`CTRL_WIDTH-1:0]);
            end else if (reg_req.addr == `RA_PORT) begin
                st_next.side_sel = reg_req.wdata[`PORT_SIDE_LSB +: 4];
                st_next.force_alarm = reg_req.wdata[`PORT_FORCE_LSB +: 4];
            end else if (reg_req.addr == `RA_TRIB0 ||
                         reg_req.addr == `RA_TRIB1 ||
                         reg_req.addr == `RA_TRIB2 ||
                         reg_req.addr == `RA_TRIB3) begin
                // Tributary registers are aligned, low bits index them.
                st_next.trib[reg_req.addr[1:0]] =
                    reg_req.wdata[`TRIB_WIDTH-1:0];
            end else if (reg_req.addr == `RA_IRQ_ENABLE) begin
                st_next.irq_enable = reg_req.wdata[3:0];
            end else begin
                // Other addresses and read-only registers ignore writes.
                st_next.cfg = st_reg.cfg;
            end
        end

        // Alarm state and the line data that follows it.
        st_next.ais = cause;
        for (int i = 0; i < `NUM_PORTS; i++) begin
            // All ones replaces the data, with no framing at all.
            st_next.data_out[i] = cause[i] ? 1'b1 :
                                  rx_e1_data_in[i];
        end

        // A new alarm wins over a clear in the same cycle.
        st_next.irq_status = (st_reg.irq_status & ~irq_clear) | rise;
        st_next.irq = |(st_next.irq_status & st_next.irq_enable);

        // Register reads answer in the next cycle only.
        if (reg_req.rd) begin
            if (reg_req.addr == `RA_CTRL) begin
                st_next.rd_data = 16'(st_reg.cfg);
            end else if (reg_req.addr == `RA_PORT) begin
                st_next.rd_data = {8'h00, st_reg.force_alarm,
                                   st_reg.side_sel};
            end else if (reg_req.addr == `RA_TRIB0 ||
                         reg_req.addr == `RA_TRIB1 ||
                         reg_req.addr == `RA_TRIB2 ||
                         reg_req.addr == `RA_TRIB3) begin
                st_next.rd_data = 16'(st_reg.trib[reg_req.addr[1:0]]);
            end else if (reg_req.addr == `RA_ALARM_STATE) begin
                // Live alarm state and FIFO holds, for software.
                st_next.rd_data = {8'h00, fifo_hold, st_reg.ais};
            end else if (reg_req.addr == `RA_IRQ_STATUS) begin
                st_next.rd_data = {12'h000, st_reg.irq_status};
            end else if (reg_req.addr == `RA_IRQ_ENABLE) begin
                st_next.rd_data = {12'h000, st_reg.irq_enable};
            end else begin
                // Unmapped and write-only addresses read as zero.
                st_next.rd_data = 16'h0000;
            end
        end
    end

    // Registers the whole state; reset forces AIS via invalid numbers.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.cfg <= qual_cfg_t'(`CTRL_RESET);
            {st_reg.force_alarm, st_reg.side_sel} <= `PORT_RESET;
            st_reg.trib <= {`NUM_PORTS{`TRIB_RESET}};
            st_reg.irq_enable <= `IRQ_ENABLE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output is a flip-flop of the state.
    assign reg_rd_data = st_reg.rd_data;
    assign rx_e1_data_out = st_reg.data_out;
    assign rx_alarm_active = st_reg.ais;
    assign irq = st_reg.irq;

    // Checks for each port.
    generate
        for (p = 0; p < `NUM_PORTS; p++) begin : g_chk
            // Base alarm of the selected side together with its side.
            sequence s_a_base;
                !st_reg.side_sel[p] && (a_side[p].loss_of_pointer ||
                a_side[p].trib_alarm_ind || a_side[p].drop_clock_loss);
            endsequence

            sequence s_b_base;
                st_reg.side_sel[p] && (b_side[p].loss_of_pointer ||
                b_side[p].trib_alarm_ind || b_side[p].drop_clock_loss);
            endsequence

            property p_a_base;
                @(posedge sys_clk) disable iff (sys_rst)
                s_a_base |=> rx_alarm_active[p];
            endproperty
            a_a_base: assert property (p_a_base)
                else $error("A side base alarm did not raise AIS.");

            property p_b_base;
                @(posedge sys_clk) disable iff (sys_rst)
                s_b_base |=> rx_alarm_active[p];
            endproperty
            a_b_base: assert property (p_b_base)
                else $error("B side base alarm did not raise AIS.");

            property p_a_upstream;
                @(posedge sys_clk) disable iff (sys_rst)
                (!st_reg.side_sel[p] && st_reg.cfg.upstream_alarm_enable &&
                 seg_pick(a_upstream_alarm, g_port[p].seg)) |=>
                rx_alarm_active[p];
            endproperty
            a_a_upstream: assert property (p_a_upstream)
                else $error("A side upstream alarm did not raise AIS.");

            // Upstream alarm of the B side, under the same enable.
            property p_b_upstream;
                @(posedge sys_clk) disable iff (sys_rst)
                (st_reg.side_sel[p] && st_reg.cfg.upstream_alarm_enable &&
                 seg_pick(b_upstream_alarm, g_port[p].seg)) |=>
                rx_alarm_active[p];
            endproperty
            a_b_upstream: assert property (p_b_upstream)
                else $error("B side upstream alarm did not raise AIS.");

            // An enabled FIFO hold keeps the port in AIS.
            property p_fifo_hold;
                @(posedge sys_clk) disable iff (sys_rst)
                (fifo_hold[p] && st_reg.cfg.rx_line_alarm_enable) |=>
                rx_alarm_active[p];
            endproperty
            a_fifo_hold: assert property (p_fifo_hold)
                else $error("FIFO error hold did not raise AIS.");

            property p_force;
                @(posedge sys_clk) disable iff (sys_rst)
                st_reg.force_alarm[p] |=> rx_alarm_active[p];
            endproperty
            a_force: assert property (p_force)
                else $error("Forced alarm did not raise AIS.");

            property p_invalid_trib;
                @(posedge sys_clk) disable iff (sys_rst)
                !trib_valid(st_reg.trib[p]) |=> rx_alarm_active[p];
            endproperty
            a_invalid_trib: assert property (p_invalid_trib)
                else $error("Invalid tributary did not raise AIS.");

            property p_quiet;
                @(posedge sys_clk) disable iff (sys_rst)
                (!st_reg.force_alarm[p] && trib_valid(st_reg.trib[p]) &&
                 !fifo_hold[p] && a_side[p] == '0 && b_side[p] == '0 &&
                 a_upstream_alarm == 3'h0 && b_upstream_alarm == 3'h0 &&
                 a_multiframe_byte_error == 3'h0 &&
                 b_multiframe_byte_error == 3'h0) |=>
                !rx_alarm_active[p];
            endproperty
            a_quiet: assert property (p_quiet)
                else $error("AIS raised with no cause.");

            property p_all_ones;
                @(posedge sys_clk) disable iff (sys_rst)
                rx_alarm_active[p] |-> rx_e1_data_out[p];
            endproperty
            a_all_ones: assert property (p_all_ones)
                else $error("AIS output is not all ones.");

            property p_sticky;
                @(posedge sys_clk) disable iff (sys_rst)
                (rise[p] && irq_clear[p]) |=> st_reg.irq_status[p];
            endproperty
            a_sticky: assert property (p_sticky)
                else $error("Alarm start lost to a clear.");
        end
    endgenerate

endmodule : rx_e1_ais_insert_ctrl

`default_nettype wire

// >>> src/side_alarm_qual.sv
`timescale 1ns/1ps
`default_nettype none

// Qualifies the alarms of one drop side of one port.
module side_alarm_qual
    import rx_ais_pkg::*;
(
    input wire side_alarm_t side,
    input wire logic seg_upstream,
    input wire logic seg_h4_error,
    input wire qual_cfg_t cfg,
    output logic alarm
);

    // Pointer, tributary alarm and clock loss always raise alarm.
    logic base; // Unconditional causes.
    logic upstream; // Upstream alarm under its enable.
    logic gated; // Causes that need the line alarm enable.
    logic trace_on; // Trace alarms are armed.
    logic tandem_on; // Tandem alarms are armed.

    // Combines the causes of this side.
    always_comb begin
        base = side.loss_of_pointer | side.trib_alarm_ind |
               side.drop_clock_loss;
        upstream = seg_upstream & cfg.upstream_alarm_enable;
        trace_on = cfg.trace_compare_enable & cfg.trace_alarm_enable &
                   ~cfg.trace_size_select;
        tandem_on = cfg.tandem_enable & cfg.tandem_alarm_enable;
        gated = (seg_h4_error & ~cfg.v1_source_select) |
                side.label_mismatch |
                (side.label_unequipped &
                 cfg.unequipped_alarm_enable) |
                (trace_on & (side.trace_lock_loss |
                             side.trace_mismatch)) |
                (tandem_on & (side.tandem_unequipped |
                              side.tandem_lock_loss |
                              side.tandem_trace_mismatch |
                              side.tandem_multiframe_loss |
                              side.tandem_alarm_ind));
        // The same gating serves both sides.
        alarm = base | upstream |
                (gated & cfg.rx_line_alarm_enable);
    end

endmodule : side_alarm_qual

`default_nettype wire

// >>> testbench/e1_line_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-end E1 line source that feeds one bit per port.
module e1_line_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    output logic [3:0] line_bits
);
    // Pattern generator state.
    logic [7:0] lfsr_reg;
    // A long sequence, so a stuck data path cannot pass by chance.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lfsr_reg <= 8'hA5;
        end else begin
            lfsr_reg <= {lfsr_reg[6:0],
                lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        end
    end
    // Each port sees a different mix of the state.
    assign line_bits = lfsr_reg[3:0] ^ lfsr_reg[7:4];
endmodule : e1_line_model

`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rx_ais_pkg::*;
    localparam int MF = 8;
    logic sys_clk, sys_rst, irq;
    reg_req_t reg_req;
    logic [15:0] reg_rd_data, rd_val;
    side_alarm_t [3:0] a_side, b_side;
    logic [2:0] a_up, b_up, a_h4, b_h4;
    logic [3:0] fifo_err, line_in, line_out, alarm, sel, frc, e, prev_in;
    logic [8:0] cfg;
    logic [3:0][6:0] trib;
    int mismatches = 0, checks_done = 0, cycles = 0;

    rx_e1_ais_insert_ctrl #(.MF_CYCLES(MF)) u_rx_e1_ais_insert_ctrl (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rd_data(reg_rd_data), .a_side(a_side), .b_side(b_side),
        .a_upstream_alarm(a_up), .b_upstream_alarm(b_up),
        .a_multiframe_byte_error(a_h4), .b_multiframe_byte_error(b_h4),
        .rx_fifo_error(fifo_err), .rx_e1_data_in(line_in),
        .rx_e1_data_out(line_out), .rx_alarm_active(alarm), .irq(irq));
    e1_line_model u_e1_line_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .line_bits(line_in));

    // Clock of 8 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Line data as it was before each edge, and the hang guard.
    always @(posedge sys_clk) begin
        prev_in <= line_in;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    // Compares one value and reports a mismatch.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One write cycle on the register port.
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask : reg_write

    // One read cycle; the data stand only in the following cycle.
    task automatic reg_read(input logic [3:0] a);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1 rd_val = reg_rd_data;
    endtask : reg_read

    // Expected alarm state of one port from its causes.
    function automatic logic exp_port(input side_alarm_t s,
        input logic [2:0] up, input logic [2:0] h4, input logic [6:0] t,
        input logic [8:0] c, input logic f);
        logic u, h, g, ok;
        u = (t[6:5] == 2'h0) ? 1'b0 : up[t[6:5] - 2'h1];
        h = (t[6:5] == 2'h0) ? 1'b0 : h4[t[6:5] - 2'h1];
        ok = (t[6:5] != 2'h0) && (t[4:0] != 5'h00) && (t[4:0] <= 5'h15);
        g = (h & ~c[6]) | (s.label_unequipped & c[5]) | s.label_mismatch
            | (c[4] & c[3] & ~c[2] & (s.trace_lock_loss | s.trace_mismatch))
            | (c[1] & c[0] & (s.tandem_unequipped | s.tandem_lock_loss
            | s.tandem_trace_mismatch | s.tandem_multiframe_loss
            | s.tandem_alarm_ind));
        return s.loss_of_pointer | s.trib_alarm_ind | s.drop_clock_loss
            | (c[7] & u) | (c[8] & g) | f | ~ok;
    endfunction : exp_port

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // Main sequence.
    initial begin
        cfg = 9'($urandom(7366));
        sys_rst = 1'b1;
        reg_req = '0;
        {a_side, b_side, a_up, b_up, a_h4, b_h4, fifo_err} = '0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check(alarm, 4'hF);
        check(line_out, 4'hF);
        reg_read(4'h0);
        check(rd_val, 16'h0000);
        reg_read(4'hC);
        check(rd_val, 16'h0000);
        // Random causes with single alarm bits, so that masking stays rare.
        for (int i = 0; i < 200; i++) begin
            cfg = 9'($urandom);
            sel = 4'($urandom);
            frc = ($urandom % 8 == 0) ? 4'($urandom) : 4'h0;
            for (int p = 0; p < 4; p++) begin
                trib[p] = {2'($urandom % 3 + 1), 5'($urandom % 23)};
                reg_write(4'h4 + 4'(p), {9'h000, trib[p]});
                a_side[p] <= side_alarm_t'(12'h001 << ($urandom % 16));
                b_side[p] <= side_alarm_t'(12'h001 << ($urandom % 16));
            end
            {a_up, b_up} <= {3'(1 << $urandom % 6), 3'(1 << $urandom % 6)};
            {a_h4, b_h4} <= {3'(1 << $urandom % 6), 3'(1 << $urandom % 6)};
            reg_write(4'h0, {7'h00, cfg});
            reg_write(4'h1, {8'h00, frc, sel});
            repeat (3) @(posedge sys_clk);
            #1 for (int p = 0; p < 4; p++) begin
                e[p] = sel[p] ? exp_port(b_side[p], b_up, b_h4, trib[p], cfg,
                    frc[p]) : exp_port(a_side[p], a_up, a_h4, trib[p], cfg,
                    frc[p]);
            end
            check(alarm, e);
            check(line_out, prev_in | e);
        end
        // A FIFO error holds the alarm for one multiframe only, and raises none with the line enable off.
        @(posedge sys_clk);
        {a_side, b_side, a_up, b_up, a_h4, b_h4} <= '0;
        for (int p = 0; p < 4; p++) reg_write(4'h4 + 4'(p), 16'h0021);
        reg_write(4'h1, 16'h0000);
        reg_write(4'h0, 16'h0100);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            fifo_err <= 4'h2;
            @(posedge sys_clk);
            fifo_err <= 4'h0;
            repeat (MF) @(posedge sys_clk);
            #1 check(alarm, k ? 4'h0 : 4'h2);
            repeat (4) @(posedge sys_clk);
            #1 check(alarm, 4'h0);
            reg_write(4'h0, 16'h0000);
        end
        // Interrupt: masked event, forced alarm, then clear.
        reg_write(4'hA, 16'h0001);
        reg_write(4'hB, 16'h0001);
        repeat (2) @(posedge sys_clk);
        #1 check(irq, 1'b0);
        reg_write(4'hA, 16'h000F);
        reg_write(4'h1, 16'h0010);
        repeat (3) @(posedge sys_clk);
        #1 check(alarm, 4'h1);
        check(irq, 1'b1);
        reg_read(4'h9);
        check(rd_val, 16'h0001);
        reg_write(4'h1, 16'h0000);
        reg_write(4'hA, 16'h0001);
        repeat (2) @(posedge sys_clk);
        #1 check(irq, 1'b0);
        complete_run();
    end
endmodule : testbench

`default_nettype wire
